/* pkg/cssu_defines.vh */
`ifndef CSSU_DEFINES_VH
`define CSSU_DEFINES_VH

// --------------------------------------------------------------------
// Register map (byte addresses, 32-bit words)
// --------------------------------------------------------------------
`define CSSU_ADDR_CTRL      8'h00
`define CSSU_ADDR_STATUS    8'h04
`define CSSU_CTRL_RESET     5'h00
`define CSSU_CTRL_MODE_LSB  0
`define CSSU_CTRL_MODE_MSB  2
`define CSSU_CTRL_SLEEP_BIT 3
`define CSSU_CTRL_ASYX_BIT  4

// --------------------------------------------------------------------
// Source-select codes
// --------------------------------------------------------------------
`define CSSU_SRC_EXT        4'h0
`define CSSU_SRC_RSVD       4'h1
`define CSSU_SRC_RC8M       4'h2
`define CSSU_SRC_RC128K     4'h3
`define CSSU_SRC_LF_LO      4'h4
`define CSSU_SRC_FS_LO      4'h6
`define CSSU_SRC_LP_LO      4'h8

// --------------------------------------------------------------------
// Oscillator input lanes
// --------------------------------------------------------------------
`define CSSU_LANE_EXT       0
`define CSSU_LANE_RC128K    1
`define CSSU_LANE_RC8M      2
`define CSSU_LANE_LF        3
`define CSSU_LANE_LP        4
`define CSSU_LANE_FS        5
`define CSSU_LANE_ASY32K    6
`define CSSU_LANE_WDOG      7
`define CSSU_LANE_WAKE      8
`define CSSU_LANES          9

// --------------------------------------------------------------------
// Sleep modes
// --------------------------------------------------------------------
`define CSSU_SLP_IDLE       3'h0
`define CSSU_SLP_NOISE      3'h1
`define CSSU_SLP_PDOWN      3'h2
`define CSSU_SLP_PSAVE      3'h3
`define CSSU_SLP_STBY       3'h6
`define CSSU_SLP_XSTBY      3'h7

// --------------------------------------------------------------------
// Timing counts (oscillator cycles)
// --------------------------------------------------------------------
`define CSSU_TOUT_NONE      16'h0000
`define CSSU_TOUT_SHORT     16'h0200
`define CSSU_TOUT_LONG      16'h2000
`define CSSU_SU_EXT         16'h0006
`define CSSU_SU_258         16'h0102
`define CSSU_SU_1K          16'h0400
`define CSSU_SU_16K         16'h4000
`define CSSU_SU_32K         16'h8000
`define CSSU_DIV8_LAST      3'h7

// --------------------------------------------------------------------
// Sequencer states
// --------------------------------------------------------------------
`define CSSU_ST_TOUT        3'h0
`define CSSU_ST_START       3'h1
`define CSSU_ST_RUN         3'h2
`define CSSU_ST_SLEEP       3'h3
`define CSSU_ST_WAKE        3'h4

`endif

/* verilog/cssu_clock_ctrl.v */
// Overview of operation
// - Route selected source into clock generator
// - Crystal oscillators chosen by code ranges
// - RC, 128k, external fixed codes; one reserved
// - Fuse bit one unprogrammed, zero programmed
// - Shipped state: internal RC divided by eight
// - Shipped start-up code gives maximum time-out
// - Extra time-out after other resets release
// - Time-out 0, 512 or 8192 watchdog cycles
// - Ripple counter holds reset for start-up
// - Start-up from 6 to 32K cycles
// - Reset: both delays; deep wake: start-up only
// - Each clock domain halted by sleep mode
// - Core clock halt stops core operation
// - Async interrupt sensing without peripheral clock
// - Serial start, address match without clock
// - Program-memory clock follows core clock
// - Async timer from external or 32 kHz
// - Async timer domain runs during sleep
// - Converter domain live with core halted
// - Programmed divide fuse divides by eight
// - Crystal start-up 258, 1K or 16K cycles
`timescale 1ns/1ps
`include "cssu_defines.vh"

module cssu_clock_ctrl #(
    parameter [15:0] TOUT_LONG_CYC = `CSSU_TOUT_LONG,
    parameter [15:0] SU_16K_CYC    = `CSSU_SU_16K,
    parameter [15:0] SU_32K_CYC    = `CSSU_SU_32K
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  clock_source_select_fuses_i,
    input  wire [1:0]  startup_time_fuses_i,
    input  wire        divide_by_eight_fuse_i,
    input  wire [8:0]  osc_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         int_reset_o,
    output reg         core_clock_en_o,
    output reg         peripheral_clock_en_o,
    output reg         program_memory_clock_en_o,
    output reg         async_timer_clock_en_o,
    output reg         converter_clock_en_o,
    output reg  [6:0]  source_onehot_o
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    reg  [8:0] sync1_reg;
    reg  [8:0] sync2_reg;
    reg  [8:0] sync3_reg;
    reg  [8:0] level_reg;
    wire [8:0] agree     = ~(sync2_reg ^ sync3_reg);
    wire [8:0] rise      = agree & sync2_reg & ~level_reg;

    // Three stages; a change counts once stages two and three agree.
    // The oscillator lanes are far slower than clk_i, so a rise is
    // seen as a level change rather than used as a clock. This keeps
    // one clock domain; a lane must hold each level two clk_i
    // cycles or longer, or its pulse is lost.

    // Only stage two feeds stage three; stage one stays private
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
            sync3_reg <= 9'h000;
            level_reg <= 9'h000;
        end else begin
            sync1_reg <= osc_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= (agree & sync2_reg) | (~agree & level_reg);
        end
    end

    // ----------------------------------------------------------------
    // Fuse capture
    // ----------------------------------------------------------------
    reg [3:0] clock_source_select_fuses_reg;
    reg [1:0] sut_reg;
    reg       div8_reg;

    // Fuses are only looked at while reset is held.
    // Holding them afterwards keeps a fuse being reprogrammed
    // mid-run from switching the source under a running core.
    always @(posedge clk_i) begin
        if (rst_i) begin
            clock_source_select_fuses_reg <= clock_source_select_fuses_i;
            sut_reg   <= startup_time_fuses_i;
            div8_reg  <= divide_by_eight_fuse_i;
        end
    end

    // ----------------------------------------------------------------
    // Source decode and start-up figures
    // ----------------------------------------------------------------
    reg  [6:0]  src_onehot;
    reg  [15:0] tout_cyc;
    reg  [15:0] su_cyc;
    wire        src_valid = (clock_source_select_fuses_reg != `CSSU_SRC_RSVD);
    wire        sel_tick  = |(src_onehot & rise[6:0]);

    // Combinational decode of the held fuses.
    // The reserved code leaves the one-hot empty, so no lane
    // ever ticks and the start-up count never completes.
    always @* begin
        src_onehot = 7'h00;
        tout_cyc   = `CSSU_TOUT_NONE;
        su_cyc     = `CSSU_SU_EXT;
        if (clock_source_select_fuses_reg >= `CSSU_SRC_LP_LO) begin
            src_onehot[`CSSU_LANE_LP] = 1'b1;
        end else if (clock_source_select_fuses_reg >= `CSSU_SRC_FS_LO) begin
            src_onehot[`CSSU_LANE_FS] = 1'b1;
        end else if (clock_source_select_fuses_reg >= `CSSU_SRC_LF_LO) begin
            src_onehot[`CSSU_LANE_LF] = 1'b1;
        end else if (clock_source_select_fuses_reg == `CSSU_SRC_RC128K) begin
            src_onehot[`CSSU_LANE_RC128K] = 1'b1;
        end else if (clock_source_select_fuses_reg == `CSSU_SRC_RC8M) begin
            src_onehot[`CSSU_LANE_RC8M] = 1'b1;
        end else if (clock_source_select_fuses_reg == `CSSU_SRC_EXT) begin
            src_onehot[`CSSU_LANE_EXT] = 1'b1;
        end
        if (clock_source_select_fuses_reg >= `CSSU_SRC_FS_LO) begin
            // Crystal and resonator table on CKSEL0 plus two STARTUP_TIME_FUSES bits
            case ({clock_source_select_fuses_reg[0], sut_reg})
                // Resonator, fast rising supply
                3'h0: begin
                    su_cyc   = `CSSU_SU_258;
                    tout_cyc = `CSSU_TOUT_SHORT;
                end
                // Resonator, slowly rising supply
                3'h1: begin
                    su_cyc   = `CSSU_SU_258;
                    tout_cyc = TOUT_LONG_CYC;
                end
                // Resonator with brown-out detector: no time-out
                3'h2: begin
                    su_cyc   = `CSSU_SU_1K;
                    tout_cyc = `CSSU_TOUT_NONE;
                end
                // Resonator, fast rising supply, long start-up
                3'h3: begin
                    su_cyc   = `CSSU_SU_1K;
                    tout_cyc = `CSSU_TOUT_SHORT;
                end
                // Resonator, slow supply, long start-up
                3'h4: begin
                    su_cyc   = `CSSU_SU_1K;
                    tout_cyc = TOUT_LONG_CYC;
                end
                // Crystal with brown-out detector: no time-out
                3'h5: begin
                    su_cyc   = SU_16K_CYC;
                    tout_cyc = `CSSU_TOUT_NONE;
                end
                // Crystal, fast rising supply
                3'h6: begin
                    su_cyc   = SU_16K_CYC;
                    tout_cyc = `CSSU_TOUT_SHORT;
                end
                // Crystal, slowly rising supply
                default: begin
                    su_cyc   = SU_16K_CYC;
                    tout_cyc = TOUT_LONG_CYC;
                end
            endcase
        end else begin
            // Slow crystal waits longest; RC and external are quick
            if (clock_source_select_fuses_reg >= `CSSU_SRC_LF_LO) begin
                su_cyc = SU_32K_CYC;
            end else begin
                su_cyc = `CSSU_SU_EXT;
            end
            case (sut_reg)
                2'h0:    tout_cyc = `CSSU_TOUT_NONE;
                2'h1:    tout_cyc = `CSSU_TOUT_SHORT;
                default: tout_cyc = TOUT_LONG_CYC;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // System prescaler
    // ----------------------------------------------------------------
    reg  [2:0] pre_reg;
    wire       div8_on  = ~div8_reg;               // Zero = programmed
    wire       div8_due = (pre_reg == `CSSU_DIV8_LAST);
    wire       sys_tick = sel_tick & (~div8_on | div8_due);

    // Free-running modulo-eight count of selected source rises.
    // It is not cleared on sleep or wake, so the first tick after
    // a wake may come sooner than eight rises; a trade for less
    // logic, since no domain relies on the phase of the divider.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pre_reg <= 3'h0;
        end else if (sel_tick) begin
            pre_reg <= pre_reg + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Register bank and bus slave
    // ----------------------------------------------------------------
    reg  [4:0] ctrl_reg;
    reg  [2:0] state_reg;
    reg        sleep_req_reg;
    wire       bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr_ctrl = bus_hit & wb_we_i & wb_sel_i[0]
                         & (wb_adr_i == `CSSU_ADDR_CTRL);

    // Single-cycle ack; write of sleep bit posts a sleep request.
    // Ack is masked by its own value, so a master that keeps the
    // request up one cycle too long is never answered twice.
    // Read data is zero outside ack, easing a wired-or bus.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0000_0000;
            ctrl_reg      <= `CSSU_CTRL_RESET;
            sleep_req_reg <= 1'b0;
        end else begin
            wb_ack_o <= bus_hit;
            wb_dat_o <= 32'h0000_0000;
            if (bus_hit & ~wb_we_i) begin
                case (wb_adr_i)
                    `CSSU_ADDR_CTRL:   wb_dat_o <= {27'h0, ctrl_reg};
                    `CSSU_ADDR_STATUS: wb_dat_o <= {21'h0, int_reset_o,
                        state_reg, div8_reg, sut_reg, clock_source_select_fuses_reg};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
            if (wr_ctrl) begin
                ctrl_reg <= {wb_dat_i[4], 1'b0, wb_dat_i[2:0]};
            end
            // Request kept until the sequencer takes it
            if (wr_ctrl & wb_dat_i[`CSSU_CTRL_SLEEP_BIT]) begin
                sleep_req_reg <= 1'b1;
            end else if (state_reg == `CSSU_ST_SLEEP) begin
                sleep_req_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Start-up sequencer
    // ----------------------------------------------------------------
    reg  [15:0] cnt_reg;
    reg  [2:0]  mode_reg;
    wire [2:0]  mode;
    assign mode = ctrl_reg[`CSSU_CTRL_MODE_MSB:`CSSU_CTRL_MODE_LSB];
    wire        wake      = level_reg[`CSSU_LANE_WAKE];
    wire        deep      = (mode_reg == `CSSU_SLP_PDOWN) |
                            (mode_reg == `CSSU_SLP_PSAVE);
    wire        wdt_tick  = rise[`CSSU_LANE_WDOG];

    // Time-out, then start-up, then run; sleep and wake loop on run.
    // Counts complete at or above their target, so a zero time-out
    // passes in a single clock. The watchdog lane is counted even
    // when the main source is dead, so the time-out always ends.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= `CSSU_ST_TOUT;
            cnt_reg   <= 16'h0000;
            mode_reg  <= `CSSU_SLP_IDLE;
        end else begin
            case (state_reg)
                `CSSU_ST_TOUT: begin
                    // Counted on the watchdog oscillator
                    if (cnt_reg >= tout_cyc) begin
                        state_reg <= `CSSU_ST_START;
                        cnt_reg   <= 16'h0000;
                    end else if (wdt_tick) begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                `CSSU_ST_START, `CSSU_ST_WAKE: begin
                    // Reserved source never ticks, so reset stays held
                    if (src_valid & (cnt_reg >= su_cyc)) begin
                        state_reg <= `CSSU_ST_RUN;
                        cnt_reg   <= 16'h0000;
                    end else if (sel_tick) begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                `CSSU_ST_RUN: begin
                    if (sleep_req_reg) begin
                        state_reg <= `CSSU_ST_SLEEP;
                        mode_reg  <= mode;
                    end
                end
                `CSSU_ST_SLEEP: begin
                    // Deep modes stopped the oscillator: wait start-up
                    if (wake & deep) begin
                        state_reg <= `CSSU_ST_WAKE;
                        cnt_reg   <= 16'h0000;
                    end else if (wake) begin
                        state_reg <= `CSSU_ST_RUN;
                    end
                end
                default: begin
                    state_reg <= `CSSU_ST_TOUT;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Domain gating
    // ----------------------------------------------------------------
    wire running = (state_reg == `CSSU_ST_RUN);
    wire asleep  = (state_reg == `CSSU_ST_SLEEP);
    wire slp_per = asleep & (mode_reg == `CSSU_SLP_IDLE);
    wire slp_cnv = asleep & ((mode_reg == `CSSU_SLP_IDLE) |
                             (mode_reg == `CSSU_SLP_NOISE));
    wire slp_asy = ~asleep | (mode_reg == `CSSU_SLP_IDLE) |
                   (mode_reg == `CSSU_SLP_NOISE) |
                   (mode_reg == `CSSU_SLP_PSAVE) |
                   (mode_reg == `CSSU_SLP_XSTBY);
    wire asy_src = ctrl_reg[`CSSU_CTRL_ASYX_BIT] ? rise[`CSSU_LANE_EXT]
                                                 : rise[`CSSU_LANE_ASY32K];

    // Enables are whole-cycle pulses, so a gated edge is never cut short.
    // Downstream logic uses them as clock enables on clk_i; no clock
    // is gated in logic, which avoids glitches at the cost of one
    // extra flop of delay between a source rise and its tick.
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_reset_o               <= 1'b1;
            core_clock_en_o           <= 1'b0;
            peripheral_clock_en_o     <= 1'b0;
            program_memory_clock_en_o <= 1'b0;
            async_timer_clock_en_o    <= 1'b0;
            converter_clock_en_o      <= 1'b0;
            source_onehot_o           <= 7'h00;
        end else begin
            int_reset_o <= (state_reg == `CSSU_ST_TOUT) |
                           (state_reg == `CSSU_ST_START);
            core_clock_en_o           <= sys_tick & running;
            program_memory_clock_en_o <= sys_tick & running;
            peripheral_clock_en_o     <= sys_tick &
                                         (running | slp_per);
            converter_clock_en_o      <= sys_tick &
                                         (running | slp_cnv);
            async_timer_clock_en_o    <= asy_src & slp_asy;
            source_onehot_o           <= src_onehot;
        end
    end

endmodule

/* dv/cssu_clock_checker.sv */
`timescale 1ns/1ps
module cssu_clock_checker (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        int_reset_o,
    input wire        core_clock_en_o,
    input wire        peripheral_clock_en_o,
    input wire        program_memory_clock_en_o,
    input wire        converter_clock_en_o,
    input wire [6:0]  source_onehot_o
);
    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    // ------------------------------------------------------------
    // Start-up hold and domain gating
    // ------------------------------------------------------------
    // Every start-up needs synced source rises, so hold lasts well past 4
    a_reset_hold: assert property (
        $fell(rst_i) |-> int_reset_o [*4])
        else $error("internal reset dropped too early");
    a_core_gated: assert property (
        int_reset_o |-> !core_clock_en_o && !peripheral_clock_en_o)
        else $error("core or peripheral tick during reset");
    a_flash_core: assert property (
        program_memory_clock_en_o == core_clock_en_o)
        else $error("program memory tick differs from core tick");
    a_run_domains: assert property (
        core_clock_en_o |-> peripheral_clock_en_o && converter_clock_en_o)
        else $error("running without all domains");
    a_conv_live: assert property (
        peripheral_clock_en_o |-> converter_clock_en_o)
        else $error("converter halted while peripheral runs");
    a_tick_single: assert property (
        core_clock_en_o |=> !core_clock_en_o)
        else $error("core tick stretched");
    a_src_onehot: assert property (
        $onehot0(source_onehot_o))
        else $error("source select not one-hot");
    a_src_held: assert property (
        !rst_i [*4] |-> $stable(source_onehot_o))
        else $error("source select changed while running");
    // Main scenarios reached
    c_core_tick: cover property (core_clock_en_o);
    c_reset_done: cover property ($fell(int_reset_o));
    c_bus_ack: cover property (wb_ack_o);
endmodule

bind cssu_clock_ctrl cssu_clock_checker cssu_clock_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_reset_o(int_reset_o),
    .core_clock_en_o(core_clock_en_o),
    .peripheral_clock_en_o(peripheral_clock_en_o),
    .program_memory_clock_en_o(program_memory_clock_en_o),
    .converter_clock_en_o(converter_clock_en_o),
    .source_onehot_o(source_onehot_o));

/* dv/tb_top.sv */
`timescale 1ns/1ps
`include "cssu_defines.vh"
module tb_top;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [3:0]  fz_src = 4'h2;
    reg  [1:0]  fz_sut = 2'h2;
    reg         fz_div = 1'b0;
    reg  [8:0]  osc_i = 9'h000;
    reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] dw = 32'h0, q;
    wire [31:0] dr;
    wire        ack, irst, c_en, p_en, f_en, a_en, v_en;
    wire [6:0]  onehot;
    integer     bad_count = 0, samples_checked = 0;
    integer     n_core = 0, n_per = 0, n_conv = 0, n_asy = 0;
    integer     i, ln, to, su;
    reg  [3:0]  s;
    reg  [2:0]  m;
    reg  [1:0]  u;
    // ------------------------------------------------------------
    // Clock, tick counters, design
    // ------------------------------------------------------------
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_core = n_core + (c_en === 1'b1);
        n_per  = n_per + (p_en === 1'b1);
        n_conv = n_conv + (v_en === 1'b1);
        n_asy  = n_asy + (a_en === 1'b1);
    end
    // Small counts keep the long start-up runs short
    cssu_clock_ctrl #(.TOUT_LONG_CYC(16'h0028), .SU_16K_CYC(16'h0014),
        .SU_32K_CYC(16'h001E)) cssu_clock_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .clock_source_select_fuses_i(fz_src),
        .startup_time_fuses_i(fz_sut), .divide_by_eight_fuse_i(fz_div),
        .osc_i(osc_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .int_reset_o(irst), .core_clock_en_o(c_en),
        .peripheral_clock_en_o(p_en), .program_memory_clock_en_o(f_en),
        .async_timer_clock_en_o(a_en), .converter_clock_en_o(v_en),
        .source_onehot_o(onehot));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Single classic cycle; waits on ack, bounded
    task xfer(input w, input [7:0] a, input [31:0] d);
        integer k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        k = 0;
        @(posedge clk_i);
        while (ack !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k = k + 1;
        end
        if (k == 20) check({31'h0, ack}, 32'h1);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Slow square pulses: each level held well past the 3-flop sync
    task rises(input integer lane, input integer n);
        repeat (n) begin
            @(posedge clk_i) osc_i[lane] <= 1'b1;
            repeat (4) @(posedge clk_i);
            osc_i[lane] <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task rd_status;
        xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
    endtask
    task restart(input [3:0] cs, input [1:0] ut, input dv);
        @(posedge clk_i);
        rst_i <= 1'b1;
        fz_src <= cs;
        fz_sut <= ut;
        fz_div <= dv;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task zero;
        n_core = 0;
        n_per = 0;
        n_conv = 0;
        n_asy = 0;
    endtask
    // Wake level must outlast the synchroniser
    task wake;
        @(posedge clk_i) osc_i[8] <= 1'b1;
        repeat (6) @(posedge clk_i);
        osc_i[8] <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count = bad_count + 1;
        results();
    end
    initial begin
        // Shipped fuses, then fuses disturbed while running
        restart(4'h2, 2'h2, 1'b0);
        rd_status();
        check(q, 32'h0000_0422);
        fz_src <= 4'hF;
        fz_sut <= 2'h0;
        fz_div <= 1'b1;
        rises(7, 39);
        rd_status();
        check(q, 32'h0000_0422);
        rises(7, 1);
        rd_status();
        check(q, 32'h0000_04A2);
        rises(2, 5);
        check({31'h0, irst}, 32'h1);
        rises(2, 1);
        repeat (4) @(posedge clk_i);
        check({31'h0, irst}, 32'h0);
        check({25'h0, onehot}, 32'h4);
        rd_status();
        check(q, 32'h0000_0122);
        xfer(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        xfer(1'b1, `CSSU_ADDR_STATUS, 32'hFFFF_FFFF);
        rd_status();
        check(q, 32'h0000_0122);
        zero();
        rises(2, 16);
        check(n_core, 32'h2);
        xfer(1'b1, `CSSU_ADDR_CTRL, 32'h10);
        xfer(1'b0, `CSSU_ADDR_CTRL, 32'h0);
        check(q, 32'h10);
        zero();
        rises(0, 2);
        rises(6, 2);
        check(n_asy, 32'h2);
        xfer(1'b1, `CSSU_ADDR_CTRL, 32'h0);
        // Each sleep mode but extended standby: which domains tick, how it wakes
        for (i = 0; i < 5; i = i + 1) begin
            m = (i == 4) ? 3'h6 : i[2:0];
            xfer(1'b1, `CSSU_ADDR_CTRL, {29'h1, m});
            rd_status();
            check({28'h0, q[10:7]}, 32'h3);
            zero();
            rises(2, 8);
            rises(6, 1);
            check(n_core, 32'h0);
            check(n_per, {31'h0, m == 3'h0});
            check(n_conv, {31'h0, m <= 3'h1});
            check(n_asy, {31'h0, m != 3'h2 && m != 3'h6});
            wake();
            rd_status();
            su = (m == 3'h2 || m == 3'h3) ? 4 : 2;
            check({28'h0, q[10:7]}, su);
            if (m == 3'h2 || m == 3'h3) begin
                rises(2, 6);
                rd_status();
                check({28'h0, q[10:7]}, 32'h2);
            end
        end
        // External clock, no time-out, undivided
        restart(4'h0, 2'h0, 1'b1);
        rises(0, 5);
        check({31'h0, irst}, 32'h1);
        rises(0, 1);
        repeat (4) @(posedge clk_i);
        check({31'h0, irst}, 32'h0);
        check({25'h0, onehot}, 32'h1);
        zero();
        rises(0, 4);
        check(n_core, 32'h4);
        // Reserved code never leaves reset
        restart(4'h1, 2'h0, 1'b1);
        rises(7, 4);
        rises(0, 8);
        check({31'h0, irst}, 32'h1);
        check({25'h0, onehot}, 32'h0);
        // Crystal ranges and their start-up counts
        for (i = 0; i < 4; i = i + 1) begin
            case (i)
                0: begin s = 4'hF; u = 2'h1; ln = 4; to = 0; su = 20; end
                1: begin s = 4'h7; u = 2'h1; ln = 5; to = 0; su = 20; end
                2: begin s = 4'h5; u = 2'h0; ln = 3; to = 0; su = 30; end
                default: begin s = 4'h6; u = 2'h0; ln = 5; to = 512; su = 258; end
            endcase
            restart(s, u, 1'b1);
            rises(7, to);
            rises(ln, su - 1);
            check({31'h0, irst}, 32'h1);
            rises(ln, 1);
            repeat (4) @(posedge clk_i);
            check({31'h0, irst}, 32'h0);
            check({25'h0, onehot}, 32'h1 << ln);
        end
        results();
    end
endmodule
